/* File: rtl/rtct_top.sv */
`timescale 1ns/1ps
module rtct_top
    import rtct_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    // slow clock sources and debug halt
    input wire logic internal_fast_osc,
    input wire logic internal_slow_osc,
    input wire logic crystal_osc,
    input wire logic external_pin_clock,
    input wire logic debug_halt,
    // interrupt
    output logic irq
);
    // ------------------------------------------------------------
    // declarations
    // ------------------------------------------------------------
    logic [4:0] raw_in;
    logic [4:0] syn_in;
    logic sel_src, src_prev, slow_tick, halted;
    logic wr_pend, rd_ok;
    logic [5:0] wr_idx;
    logic [7:0] wbyte;
    logic [7:0] counter_control, drift_correction, source_select;
    logic [15:0] tick_count, wrap_limit, match_value, count_shadow, limit_shadow;
    logic [7:0] tick_timer_control, tick_timer_live;
    logic pit_irq_en, pit_flag, halt_bypass;
    logic [1:0] cnt_irq_en, cnt_flags;
    logic count_busy, count_apply, limit_busy, limit_apply, ctrl_busy, ctrl_apply;
    logic [15:0] pre_cnt, pre_lim, pre_sum;
    logic [1:0] pre_step;
    logic [19:0] corr_acc, corr_sum;
    logic corr_event, count_tick, pit_tick;
    logic [14:0] pit_cnt;
    logic [3:0] pit_code;
    logic pit_on;
    logic [15:0] next_count;
    logic [31:0] rd_val;
    logic [1:0] count_seen;

    function automatic logic hit(input logic pend, input logic [5:0] idx, input logic [5:0] k);
        hit = pend && (idx == k);
    endfunction

    function automatic logic [15:0] div_limit(input logic [3:0] code);
        div_limit = (16'h0001 << code) - 16'h0001;
    endfunction

    function automatic logic [14:0] period_mask(input logic [3:0] code);
        period_mask = 15'(16'((16'h0002 << code) - 16'h0001));
    endfunction

    // ------------------------------------------------------------
    // pin synchronisers and slow tick
    // ------------------------------------------------------------
    assign raw_in = {debug_halt, external_pin_clock, crystal_osc, internal_slow_osc,
                     internal_fast_osc};

    genvar gi;
    generate
        for (gi = 0; gi < 5; gi++)
        begin : g_sync
            rtct_sync2 u_sync (
                .hclk(hclk),
                .hresetn(hresetn),
                .async_in(raw_in[gi]),
                .sync_out(syn_in[gi])
            );
        end
    endgenerate

    assign sel_src = syn_in[source_select[1:0]];
    assign halted = syn_in[4];

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            src_prev <= 1'b0;
            slow_tick <= 1'b0;
        end
        else
        begin
            src_prev <= sel_src;
            slow_tick <= sel_src && !src_prev;
        end
    end

    // ------------------------------------------------------------
    // ahb-lite bus slave, zero wait states
    // ------------------------------------------------------------
    assign wbyte = hwdata[7:0];
    assign rd_ok = hsel && htrans[1] && hready && !hwrite;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend <= 1'b0;
            wr_idx <= 6'h00;
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b0;
            hresp <= 1'b0;
        end
        else
        begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            wr_pend <= hsel && htrans[1] && hready && hwrite && (haddr[31:8] == 24'h0);
            wr_idx <= haddr[7:2];
            if (rd_ok)
            begin
                hrdata <= (haddr[31:8] == 24'h0) ? rd_val : 32'h0000_0000;
            end
        end
    end

    always_comb
    begin
        rd_val = 32'h0000_0000;
        case (haddr[7:2])
            IDX_COUNTER_CONTROL: rd_val[7:0] = counter_control;
            IDX_COUNTER_STATUS: rd_val[2:1] = {limit_busy, count_busy};
            IDX_COUNTER_IRQ_ENABLE: rd_val[1:0] = cnt_irq_en;
            IDX_COUNTER_IRQ_FLAG: rd_val[1:0] = cnt_flags;
            IDX_DRIFT_CORRECTION: rd_val[7:0] = drift_correction;
            IDX_SOURCE_SELECT: rd_val[1:0] = source_select[1:0];
            IDX_TICK_COUNT: rd_val[7:0] = tick_count[7:0];
            IDX_TICK_COUNT + IDX_HIGH_BYTE: rd_val[7:0] = tick_count[15:8];
            IDX_WRAP_LIMIT: rd_val[7:0] = wrap_limit[7:0];
            IDX_WRAP_LIMIT + IDX_HIGH_BYTE: rd_val[7:0] = wrap_limit[15:8];
            IDX_MATCH_VALUE: rd_val[7:0] = match_value[7:0];
            IDX_MATCH_VALUE + IDX_HIGH_BYTE: rd_val[7:0] = match_value[15:8];
            IDX_TICK_TIMER_CONTROL: rd_val[7:0] = tick_timer_control;
            IDX_TICK_TIMER_SYNC_STATE: rd_val[0] = ctrl_busy;
            IDX_TICK_TIMER_IRQ_ENABLE: rd_val[0] = pit_irq_en;
            IDX_TICK_TIMER_IRQ_FLAG: rd_val[0] = pit_flag;
            IDX_TICK_TIMER_HALT_CONTROL: rd_val[0] = halt_bypass;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            counter_control <= RST_ZERO8;
            drift_correction <= RST_ZERO8;
            source_select <= RST_ZERO8;
            match_value <= RST_ZERO16;
            count_shadow <= RST_ZERO16;
            limit_shadow <= RST_WRAP_LIMIT;
            tick_timer_control <= RST_ZERO8;
            cnt_irq_en <= 2'b00;
            pit_irq_en <= 1'b0;
            halt_bypass <= 1'b0;
        end
        else
        begin
            if (hit(wr_pend, wr_idx, IDX_COUNTER_CONTROL))
                counter_control <= {1'b0, wbyte[6:0]};
            if (hit(wr_pend, wr_idx, IDX_DRIFT_CORRECTION))
                drift_correction <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_SOURCE_SELECT))
                source_select <= {6'h00, wbyte[1:0]};
            if (hit(wr_pend, wr_idx, IDX_MATCH_VALUE))
                match_value[7:0] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_MATCH_VALUE + IDX_HIGH_BYTE))
                match_value[15:8] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_TICK_COUNT))
                count_shadow[7:0] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_TICK_COUNT + IDX_HIGH_BYTE))
                count_shadow[15:8] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_WRAP_LIMIT))
                limit_shadow[7:0] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_WRAP_LIMIT + IDX_HIGH_BYTE))
                limit_shadow[15:8] <= wbyte;
            if (hit(wr_pend, wr_idx, IDX_TICK_TIMER_CONTROL))
                tick_timer_control <= {1'b0, wbyte[6:3], 2'b00, wbyte[0]};
            if (hit(wr_pend, wr_idx, IDX_COUNTER_IRQ_ENABLE))
                cnt_irq_en <= wbyte[1:0];
            if (hit(wr_pend, wr_idx, IDX_TICK_TIMER_IRQ_ENABLE))
                pit_irq_en <= wbyte[0];
            if (hit(wr_pend, wr_idx, IDX_TICK_TIMER_HALT_CONTROL))
                halt_bypass <= wbyte[0];
        end
    end

    // ------------------------------------------------------------
    // crossings into the slow tick domain
    // ------------------------------------------------------------
    rtct_xfer u_count_xfer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(hit(wr_pend, wr_idx, IDX_TICK_COUNT) ||
               hit(wr_pend, wr_idx, IDX_TICK_COUNT + IDX_HIGH_BYTE)),
        .slow_tick(slow_tick),
        .busy(count_busy),
        .apply(count_apply)
    );

    rtct_xfer u_limit_xfer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(hit(wr_pend, wr_idx, IDX_WRAP_LIMIT) ||
               hit(wr_pend, wr_idx, IDX_WRAP_LIMIT + IDX_HIGH_BYTE)),
        .slow_tick(slow_tick),
        .busy(limit_busy),
        .apply(limit_apply)
    );

    rtct_xfer u_ctrl_xfer (
        .hclk(hclk),
        .hresetn(hresetn),
        .start(hit(wr_pend, wr_idx, IDX_TICK_TIMER_CONTROL)),
        .slow_tick(slow_tick),
        .busy(ctrl_busy),
        .apply(ctrl_apply)
    );

    // ------------------------------------------------------------
    // prescaler with drift correction
    // ------------------------------------------------------------
    assign corr_sum = corr_acc + {13'h0000, drift_correction[6:0]};
    assign corr_event = slow_tick && counter_control[POS_CORRECTION_ON]
                        && counter_control[POS_COUNTER_ON] && (corr_sum >= CORR_INTERVAL);
    assign pre_lim = div_limit(counter_control[POS_PRESCALE_LO +: 4]);

    always_comb
    begin
        pre_step = 2'd1;
        if (corr_event)
            pre_step = drift_correction[POS_DIRECTION] ? 2'd2 : 2'd0;
    end

    assign pre_sum = pre_cnt + {14'h0000, pre_step};
    assign count_tick = slow_tick && counter_control[POS_COUNTER_ON] && (pre_sum > pre_lim);

    // one correction each time the ppm sum passes a million keeps them spread out
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            corr_acc <= 20'h00000;
        else if (slow_tick && counter_control[POS_CORRECTION_ON]
                 && counter_control[POS_COUNTER_ON])
            corr_acc <= corr_event ? corr_sum - CORR_INTERVAL : corr_sum;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pre_cnt <= RST_ZERO16;
        else if (!counter_control[POS_COUNTER_ON])
            pre_cnt <= RST_ZERO16;
        else if (slow_tick)
            pre_cnt <= count_tick ? pre_sum - pre_lim - 16'h0001 : pre_sum;
    end

    // ------------------------------------------------------------
    // counter, wrap and match, counter flags
    // ------------------------------------------------------------
    assign next_count = (tick_count == wrap_limit) ? RST_ZERO16 : tick_count + 16'h0001;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_count <= RST_ZERO16;
            wrap_limit <= RST_WRAP_LIMIT;
        end
        else
        begin
            if (count_apply)
                tick_count <= count_shadow;
            else if (count_tick)
                tick_count <= next_count;
            if (limit_apply)
                wrap_limit <= limit_shadow;
        end
    end

    // set wins over a write-one clear in the same cycle
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_flags <= 2'b00;
        else
        begin
            if (hit(wr_pend, wr_idx, IDX_COUNTER_IRQ_FLAG))
                cnt_flags <= cnt_flags & ~wbyte[1:0];
            if (count_tick && !count_apply && tick_count == wrap_limit)
                cnt_flags[POS_WRAP] <= 1'b1;
            if (count_tick && !count_apply && next_count == match_value)
                cnt_flags[POS_MATCH] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // periodic tick timer
    // ------------------------------------------------------------
    assign pit_code = tick_timer_live[POS_PERIOD_LO +: 4];
    assign pit_on = tick_timer_live[POS_TICK_TIMER_ON];
    assign pit_tick = slow_tick && pit_on && (halt_bypass || !halted)
                      && pit_code != PERIOD_OFF && pit_code != PERIOD_RESERVED
                      && ((pit_cnt & period_mask(pit_code)) == period_mask(pit_code));

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            tick_timer_live <= RST_ZERO8;
            pit_cnt <= 15'h0000;
        end
        else
        begin
            if (ctrl_apply)
                tick_timer_live <= tick_timer_control;
            if (!pit_on)
                pit_cnt <= 15'h0000;
            else if (slow_tick && (halt_bypass || !halted))
                pit_cnt <= pit_cnt + 15'h0001;
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pit_flag <= 1'b0;
        else if (pit_tick)
            pit_flag <= 1'b1;
        else if (hit(wr_pend, wr_idx, IDX_TICK_TIMER_IRQ_FLAG) && wbyte[0])
            pit_flag <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            irq <= 1'b0;
        else
            irq <= (pit_flag && pit_irq_en) || |(cnt_flags & cnt_irq_en);
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    // slow ticks seen since the last count write, held against the sync latency
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            count_seen <= 2'd0;
        else if (hit(wr_pend, wr_idx, IDX_TICK_COUNT)
                 || hit(wr_pend, wr_idx, IDX_TICK_COUNT + IDX_HIGH_BYTE))
            count_seen <= 2'd0;
        else if (count_busy && slow_tick && count_seen != 2'd3)
            count_seen <= count_seen + 2'd1;
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    a_neg_corr_step: assert property (corr_event && drift_correction[7] |-> pre_step == 2'd2)
        else $error("negative correction did not add a step");
    a_pos_corr_hold: assert property (corr_event && !drift_correction[7] |-> !count_tick
        || pre_cnt > pre_lim)
        else $error("positive correction still advanced");
    a_acc_bound: assert property (corr_acc < CORR_INTERVAL)
        else $error("correction sum out of range");
    a_corr_gated: assert property (!counter_control[2] |=> $stable(corr_acc))
        else $error("correction ran while disabled");
    a_read_high: assert property (rd_ok && haddr == 32'h0000_0024 |=>
        hrdata == {24'h0, $past(tick_count[15:8])})
        else $error("count high byte misread");
    a_count_latency: assert property (count_apply |-> count_seen == SYNC_TICKS)
        else $error("count applied before two slow ticks");
    a_wrap_zero: assert property (count_tick && !count_apply && tick_count == wrap_limit |=>
        tick_count == 16'h0000 && cnt_flags[0])
        else $error("wrap did not return to zero");
    a_pit_silent: assert property (pit_code == 4'h0 || pit_code == 4'hF || !pit_on
        |-> !pit_tick)
        else $error("tick with timer off");
    a_pit_flag_set: assert property (pit_tick |=> pit_flag)
        else $error("tick flag not set");
    a_pit_halted: assert property (halted && !halt_bypass |-> !pit_tick ##1 1'b1)
        else $error("timer ran while halted");
    a_irq_gate: assert property (!pit_irq_en && cnt_flags == 2'b00 ##1 !pit_irq_en
        && cnt_flags == 2'b00 |-> !irq)
        else $error("interrupt without enable");

    c_wrap: cover property (count_tick && tick_count == wrap_limit);
    c_pit_tick: cover property (pit_tick ##1 irq);
    c_corr: cover property (corr_event);
endmodule // rtct_top

/* File: pkg/rtct_pkg.sv */
// Summary of operation
// - direction bit zero slows, one speeds prescaler
// - magnitude gives correction clocks per million cycles
// - source_select picks one of four slow clocks
// - low byte at base, high byte next
// - count and limit writes apply after two ticks
// - period code sets interval, zero and fifteen silent
// - tick_timer_on switches the periodic timer
// - sync state bit shows control write pending
// - irq enable gates the periodic interrupt request
// - periodic tick sets flag, write one clears
// - debug halt stops timer unless halt_bypass set
// - match and wrap flags follow count events
// - correction acts only with correction_on set
package rtct_pkg;
    // ------------------------------------------------------------
    // register indices, byte address is four times the index
    // ------------------------------------------------------------
    localparam logic [5:0] IDX_COUNTER_CONTROL = 6'h00;
    localparam logic [5:0] IDX_COUNTER_STATUS = 6'h01;
    localparam logic [5:0] IDX_COUNTER_IRQ_ENABLE = 6'h02;
    localparam logic [5:0] IDX_COUNTER_IRQ_FLAG = 6'h03;
    localparam logic [5:0] IDX_DRIFT_CORRECTION = 6'h06;
    localparam logic [5:0] IDX_SOURCE_SELECT = 6'h07;
    localparam logic [5:0] IDX_TICK_COUNT = 6'h08;
    localparam logic [5:0] IDX_WRAP_LIMIT = 6'h0A;
    localparam logic [5:0] IDX_MATCH_VALUE = 6'h0C;
    localparam logic [5:0] IDX_HIGH_BYTE = 6'h01;
    localparam logic [5:0] IDX_TICK_TIMER_CONTROL = 6'h10;
    localparam logic [5:0] IDX_TICK_TIMER_SYNC_STATE = 6'h11;
    localparam logic [5:0] IDX_TICK_TIMER_IRQ_ENABLE = 6'h12;
    localparam logic [5:0] IDX_TICK_TIMER_IRQ_FLAG = 6'h13;
    localparam logic [5:0] IDX_TICK_TIMER_HALT_CONTROL = 6'h15;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int POS_COUNTER_ON = 0;
    localparam int POS_CORRECTION_ON = 2;
    localparam int POS_PRESCALE_LO = 3;
    localparam int POS_DIRECTION = 7;
    localparam int POS_COUNT_BUSY = 1;
    localparam int POS_LIMIT_BUSY = 2;
    localparam int POS_WRAP = 0;
    localparam int POS_MATCH = 1;
    localparam int POS_TICK_TIMER_ON = 0;
    localparam int POS_PERIOD_LO = 3;
    // ------------------------------------------------------------
    // reset values and counts
    // ------------------------------------------------------------
    localparam logic [15:0] RST_WRAP_LIMIT = 16'hFFFF;
    localparam logic [15:0] RST_ZERO16 = 16'h0000;
    localparam logic [7:0] RST_ZERO8 = 8'h00;
    localparam logic [19:0] CORR_INTERVAL = 20'd1000000;
    localparam logic [1:0] SYNC_TICKS = 2'd2;
    localparam logic [3:0] PERIOD_OFF = 4'h0;
    localparam logic [3:0] PERIOD_RESERVED = 4'hF;
    localparam logic [1:0] SRC_INTERNAL_FAST_OSC = 2'h0;
    localparam logic [1:0] SRC_INTERNAL_SLOW_OSC = 2'h1;
    localparam logic [1:0] SRC_CRYSTAL_OSC = 2'h2;
    localparam logic [1:0] SRC_EXTERNAL_PIN_CLOCK = 2'h3;
endpackage

/* File: rtl/rtct_sync2.sv */
`timescale 1ns/1ps
module rtct_sync2
    import rtct_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // level in and out
    input wire logic async_in,
    output logic sync_out
);
    logic stage1;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            stage1 <= 1'b0;
            sync_out <= 1'b0;
        end
        else
        begin
            stage1 <= async_in;
            sync_out <= stage1;
        end
    end
endmodule // rtct_sync2

/* File: rtl/rtct_xfer.sv */
`timescale 1ns/1ps
module rtct_xfer
    import rtct_pkg::*;
(
    // clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // request and slow tick
    input wire logic start,
    input wire logic slow_tick,
    // status
    output logic busy,
    output logic apply
);
    logic [1:0] ticks;

    // a new write restarts the wait of two slow ticks
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            busy <= 1'b0;
            ticks <= 2'd0;
            apply <= 1'b0;
        end
        else
        begin
            apply <= 1'b0;
            if (start)
            begin
                busy <= 1'b1;
                ticks <= 2'd0;
            end
            else if (busy && slow_tick)
            begin
                if (ticks == SYNC_TICKS - 2'd1)
                begin
                    busy <= 1'b0;
                    apply <= 1'b1;
                end
                ticks <= ticks + 2'd1;
            end
        end
    end
endmodule // rtct_xfer

/* File: dv/rtct_top_tb_top.sv */
`timescale 1ns/1ps
module rtct_top_tb_top;
    import rtct_pkg::*;
    // ------
    // bus, pins and model
    // ------
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [31:0] hwdata = 32'h0;
    logic [7:0] osc = 8'h00;
    logic debug_halt = 1'b0;
    logic hready;
    logic hreadyout;
    logic hresp;
    logic irq;
    logic [31:0] hrdata;
    logic [31:0] rd;
    logic [7:0] exp_reg [64];
    logic [5:0] ri [15] = '{6'h06, 6'h07, 6'h08, 6'h09, 6'h0A, 6'h0B, 6'h0C, 6'h0D,
        6'h10, 6'h11, 6'h12, 6'h13, 6'h15, 6'h0E, 6'h3F};
    logic [5:0] wi [6] = '{6'h06, 6'h07, 6'h0C, 6'h0D, 6'h12, 6'h15};
    logic [7:0] wm [6] = '{8'hFF, 8'h03, 8'hFF, 8'hFF, 8'h01, 8'h01};
    logic [7:0] nv [4] = '{8'h01, 8'h79, 8'h08, 8'h09};
    int fail_count = 0;
    int total_checks = 0;
    int now = 0;
    int t0;
    assign hready = hreadyout;
    rtct_top uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .internal_fast_osc(osc[3]), .internal_slow_osc(osc[4]), .crystal_osc(osc[5]),
        .external_pin_clock(osc[6]), .debug_halt(debug_halt), .irq(irq)
    );
    initial
    begin
        forever #10 hclk = ~hclk;
    end
    // slow clock pins, fast source toggles every 8 cycles
    always @(posedge hclk)
    begin
        now <= now + 1;
        osc <= osc + 8'h01;
    end
    // ------
    // tasks
    // ------
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e)
        begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_rng(input string n, input int v, input int lo, input int hi);
        total_checks++;
        if (v < lo || v > hi)
        begin
            fail_count++;
            $display("wrong value %s expected %0d..%0d seen %0d", n, lo, hi, v);
        end
    endtask
    task automatic bus(input logic w, input logic [5:0] i, input logic [7:0] d);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h0, i, 2'h0};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, d};
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask
    task automatic wr(input logic [5:0] i, input logic [7:0] d);
        bus(1'b1, i, d);
        exp_reg[i] = d;
    endtask
    task automatic rdchk(input logic [5:0] i);
        bus(1'b0, i, 8'h00);
        chk($sformatf("reg %h", i), {24'h0, exp_reg[i]}, rd);
    endtask
    task automatic wait_bit(input logic [5:0] i, input int b, input logic v);
        int n;
        n = 0;
        bus(1'b0, i, 8'h00);
        while (rd[b] !== v && n < 400)
        begin
            n++;
            bus(1'b0, i, 8'h00);
        end
        chk_rng("poll count", n, 0, 399);
    endtask
    task automatic test_done;
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    initial
    begin
        #(20 * 60000);
        fail_count++;
        test_done();
    end
    // ------
    // main sequence
    // ------
    initial
    begin
        void'($urandom(86456));
        foreach (exp_reg[i]) exp_reg[i] = 8'h00;
        exp_reg[6'h0A] = 8'hFF;
        exp_reg[6'h0B] = 8'hFF;
        repeat (6) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (ri[k]) rdchk(ri[k]);
        for (int k = 0; k < 6; k++) wr(wi[k], 8'($urandom) & wm[k]);
        bus(1'b1, 6'h0E, 8'($urandom));
        foreach (ri[k]) rdchk(ri[k]);
        wr(6'h07, 8'h00);
        for (int k = 0; k < 2; k++)
        begin
            for (int b = 0; b < 2; b++)
            begin
                t0 = now;
                wr(6'h08 + 6'(2 * k + b), 8'($urandom));
                wait_bit(6'h01, k + 1, 1'b0);
                chk_rng("sync time", now - t0, 16, 150);
            end
            rdchk(6'h08 + 6'(2 * k));
            rdchk(6'h09 + 6'(2 * k));
        end
        wr(6'h12, 8'h01);
        wr(6'h15, 8'h00);
        for (int c = 1; c < 5; c++)
        begin
            t0 = now;
            wr(6'h10, 8'((c << 3) | 1));
            wait_bit(6'h11, 0, 1'b0);
            chk_rng("ctrl sync", now - t0, 16, 150);
            rdchk(6'h10);
            wait_bit(6'h13, 0, 1'b1);
            chk("irq", 32'h1, {31'h0, irq});
            wr(6'h13, 8'h01);
            wait_bit(6'h13, 0, 1'b1);
            wr(6'h13, 8'h01);
            t0 = now;
            wait_bit(6'h13, 0, 1'b1);
            chk_rng("period", now - t0, (64 << (c - 1)) - 10, (64 << (c - 1)) + 4);
        end
        wr(6'h12, 8'h00);
        rdchk(6'h12);
        chk("irq masked", 32'h0, {31'h0, irq});
        for (int k = 0; k < 4; k++)
        begin
            wr(6'h10, nv[k]);
            wait_bit(6'h11, 0, 1'b0);
            debug_halt <= (k == 3);
            wr(6'h13, 8'h01);
            repeat (300) @(posedge hclk);
            bus(1'b0, 6'h13, 8'h00);
            chk("quiet flag", 32'h0, rd);
        end
        wr(6'h15, 8'h01);
        wait_bit(6'h13, 0, 1'b1);
        debug_halt <= 1'b0;
        for (int k = 0; k < 4; k++)
        begin
            wr(6'h08 + 6'(k), (k == 2) ? 8'h03 : 8'h00);
            wait_bit(6'h01, 1 + k / 2, 1'b0);
        end
        wr(6'h0C, 8'h02);
        wr(6'h0D, 8'h00);
        wr(6'h02, 8'h03);
        wr(6'h00, 8'h0D);
        wait_bit(6'h03, 1, 1'b1);
        wait_bit(6'h03, 0, 1'b1);
        chk("counter irq", 32'h1, {31'h0, irq});
        test_done();
    end
endmodule // rtct_top_tb_top
